// ==== pvs_buf2.sv ====
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes one clock; out_valid_o and out_data_o come from flip-flops.
 */
`timescale 1ns/1ps
module pvs_buf2 #(
  parameter int W = 18
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  typedef struct packed {
    logic v0;
    logic v1;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } pvs_buf_t;

  pvs_buf_t st;
  pvs_buf_t next_st;

  assign in_ready_o = ~st.v1;
  assign out_valid_o = st.v0;
  assign out_data_o = st.e0;

  always_comb begin
    next_st = st;
    if (st.v0 && out_ready_i) begin
      next_st.e0 = st.e1;
      next_st.v0 = st.v1;
      next_st.v1 = 1'b0;
    end
    if (in_valid_i && !st.v1) begin
      if (!next_st.v0) begin
        next_st.e0 = in_data_i;
        next_st.v0 = 1'b1;
      end else begin
        next_st.e1 = in_data_i;
        next_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ==== pvs_codec.sv ====
/* behavioural codec at the far side of the voice port; it can also
   master the bit clock and short sync.
   assumes bclk_i and sync_i are the resolved bus lines. */
`timescale 1ns/1ps
module pvs_codec #(
  parameter int FRAME = 32
) (
  input logic run_i,
  input logic bclk_i,
  input logic sync_i,
  input logic dout_i,
  input logic dout_oe_i,
  input logic [3:0] slot_i,
  input logic [15:0] word_i,
  output logic bclk_o,
  output logic sync_o,
  output logic din_o,
  output logic [15:0] got_o,
  output int words_o,
  output int leak_o
);
  int gen_n = 0;
  int bit_n = 999;
  logic start = 1'b0;
  logic [15:0] sh = 16'h0000;
  initial begin
    bclk_o = 1'b0;
    sync_o = 1'b0;
    din_o = 1'b0;
    words_o = 0;
    leak_o = 0;
  end
  // ********
  // clock and sync, then slot traffic
  // ********
  always begin
    #40;
    bclk_o = run_i ? ~bclk_o : 1'b0;
  end
  always @(posedge bclk_o) begin
    gen_n = (gen_n + 1) % FRAME;
    sync_o <= (gen_n == FRAME - 1);
  end
  always @(posedge bclk_i) begin
    bit_n = start ? 0 : bit_n + 1;
    start = 1'b0;
    // outside its slot the line toggles so stale bits never match
    din_o = (bit_n / 16 == slot_i) ? word_i[15 - bit_n % 16] : ~din_o;
  end
  always @(negedge bclk_i) begin
    if (sync_i === 1'b1) begin
      start = 1'b1;
    end
    if (bit_n / 16 == slot_i) begin
      sh = {sh[14:0], dout_oe_i ? dout_i : 1'bx};
      if (bit_n % 16 == 15) begin
        got_o = sh;
        words_o++;
      end
    end else if (dout_oe_i && bit_n < FRAME) begin
      leak_o++;
    end
  end
endmodule

// ==== pvs_pkg.sv ====
/*
 * package of the pcm voice slot port: register offsets, field positions,
 * reset values and enumerations.
 * assumes byte addresses on a 32-bit classic wishbone bus.
 */
package pvs_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FMT = 8'h04;
  localparam logic [7:0] ADR_SLOT = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  localparam logic [7:0] ADR_DIV = 8'h10;
  localparam logic [7:0] ADR_TX0 = 8'h14;
  localparam logic [7:0] ADR_TX1 = 8'h18;
  localparam logic [7:0] ADR_TX2 = 8'h1c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_LONG = 2;
  localparam int CTRL_FS = 3;
  localparam int CTRL_RATE = 5;
  localparam int CTRL_MODE = 8;
  localparam int FMT_POS = 0;
  localparam int FMT_MSB = 2;
  localparam int FMT_FILL = 3;
  localparam int FMT_CONST = 5;
  localparam int SLOT_SEL = 8;
  localparam int STAT_UNR = 4;
  localparam int STAT_LOCK = 8;
  localparam int TX_FULL = 31;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FMT_RST = 32'h0000_0007;
  localparam logic [31:0] SLOT_RST = 32'h0002_0100;
  localparam logic [15:0] DIV_RST = 16'h001e;
  localparam int NCH = 3;
  localparam int SLOT_BITS = 16;
  localparam int SAMPLE_BITS = 13;
  localparam int LONG_SYNC_BITS = 3;
  localparam logic [2:0] RATE_MAX = 3'h4;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {FS_8K, FS_16K, FS_4K} pvs_fs_t;
  typedef enum logic [1:0] {MODE_LINEAR, MODE_TRANSPARENT, MODE_ONCHIP} pvs_mode_t;
  typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_CONST} pvs_fill_t;

endpackage

// ==== pvs_port.sv ====
/*
 * pcm voice slot port: bit clock and frame sync master or slave, three
 * full-duplex voice channels mapped to 16-bit slots, sample formatting,
 * wishbone register slave, received words through a two-entry buffer.
 * assumes pins are outside the clk_i domain and pass two flip-flops.
 */
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module pvs_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe_o,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic rx_valid_o,
  output logic [15:0] rx_data_o,
  output logic [1:0] rx_chan_o,
  input wire logic rx_ready_i
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] fmt;
    logic [31:0] slot;
    logic [15:0] div;
    logic [2:0] ovr;
    logic [2:0] unr;
    logic [2:0] full;
    logic [2:0][15:0] hold;
    logic ack;
    logic [31:0] rdat;
    logic [1:0] bclk_sy;
    logic [1:0] sync_sy;
    logic [1:0] din_sy;
    logic bc_prev;
    logic fs_prev;
    logic [15:0] dcnt;
    logic bclk;
    logic [9:0] bitcnt;
    logic lock;
    logic active;
    logic [1:0] ch;
    logic [15:0] txsh;
    logic [15:0] rxsh;
    logic dout;
    logic dout_oe;
    logic sync;
    logic pin_oe;
    logic push;
    logic [17:0] pdata;
  } pvs_state_t;

  pvs_state_t st;
  pvs_state_t next_st;
  logic buf_ready;
  logic [17:0] buf_q;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // builds the transmitted slot word from a held sample
  function automatic logic [15:0] fmt_tx(input logic [15:0] s, input logic [31:0] f,
                                         input logic raw);
    logic [15:0] w;
    int p;
    p = int'(f[pvs_pkg::FMT_POS +: 2]);
    w = '0;
    for (int i = 0; i < pvs_pkg::SLOT_BITS; i++) begin
      if (i >= p && i < p + pvs_pkg::SAMPLE_BITS) begin
        w[i] = s[i-p];
      end else begin
        case (pvs_pkg::pvs_fill_t'(f[pvs_pkg::FMT_FILL +: 2]))
          pvs_pkg::FILL_ZERO: w[i] = 1'b0;
          pvs_pkg::FILL_ONE: w[i] = 1'b1;
          pvs_pkg::FILL_SIGN: w[i] = s[pvs_pkg::SAMPLE_BITS-1];
          default: w[i] = f[pvs_pkg::FMT_CONST + ((i < p) ? i : i - pvs_pkg::SAMPLE_BITS)];
        endcase
      end
    end
    return raw ? s : w;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic en;
    logic master;
    logic raw;
    logic msb;
    logic bc;
    logic rise;
    logic fall;
    logic m;
    logic [1:0] mc;
    logic [2:0] rate;
    logic [10:0] flen;
    logic [9:0] nb;
    logic [3:0] idx;
    logic [2:0] oset;
    logic [2:0] uset;
    logic [2:0] clr_o;
    logic [2:0] clr_u;
    logic [15:0] rxw;
    en = st.ctrl[pvs_pkg::CTRL_EN];
    master = st.ctrl[pvs_pkg::CTRL_MASTER];
    raw = pvs_pkg::pvs_mode_t'(st.ctrl[pvs_pkg::CTRL_MODE +: 2]) != pvs_pkg::MODE_LINEAR;
    msb = st.fmt[pvs_pkg::FMT_MSB];
    m = 1'b0;
    mc = 2'h0;
    oset = 3'h0;
    uset = 3'h0;
    clr_o = 3'h0;
    clr_u = 3'h0;
    rxw = 16'h0000;
    idx = 4'h0;
    nb = 10'h000;
    rate = 3'h0;
    flen = 11'h000;
    bc = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.push = 1'b0;
    next_st.bclk_sy = {st.bclk_sy[0], bclk_i};
    next_st.sync_sy = {st.sync_sy[0], sync_i};
    next_st.din_sy = {st.din_sy[0], din_i};

    // frame length in bits from interface rate and sample rate
    rate = (st.ctrl[pvs_pkg::CTRL_RATE +: 3] > pvs_pkg::RATE_MAX) ? pvs_pkg::RATE_MAX
         : st.ctrl[pvs_pkg::CTRL_RATE +: 3];
    case (pvs_pkg::pvs_fs_t'(st.ctrl[pvs_pkg::CTRL_FS +: 2]))
      pvs_pkg::FS_16K: flen = 11'h008 << rate;
      pvs_pkg::FS_4K: flen = 11'h020 << rate;
      default: flen = 11'h010 << rate;
    endcase

    // bit clock source and edges
    if (en && master) begin
      if (st.dcnt == 16'h0000) begin
        next_st.bclk = ~st.bclk;
        next_st.dcnt = st.div;
      end else begin
        next_st.dcnt = st.dcnt - 16'h0001;
      end
    end
    bc = master ? st.bclk : st.bclk_sy[1];
    next_st.bc_prev = bc;
    rise = bc & ~st.bc_prev;
    fall = ~bc & st.bc_prev;
    next_st.pin_oe = en & master;

    if (!en) begin
      next_st.bclk = 1'b0;
      next_st.dcnt = 16'h0000;
      next_st.bitcnt = 10'h000;
      next_st.lock = 1'b0;
      next_st.active = 1'b0;
      next_st.dout_oe = 1'b0;
      next_st.sync = 1'b0;
    end else if (rise) begin
      nb = (11'(st.bitcnt) >= flen - 11'h001) ? 10'h000 : st.bitcnt + 10'h001;
      next_st.bitcnt = nb;
      if (master) begin
        next_st.lock = 1'b1;
        if (st.ctrl[pvs_pkg::CTRL_LONG]) begin
          next_st.sync = nb < 10'(pvs_pkg::LONG_SYNC_BITS);
        end else begin
          next_st.sync = 11'(nb) == flen - 11'h001;
        end
      end
      // slot n occupies bits 16n to 16n+15
      for (int k = 0; k < pvs_pkg::NCH; k++) begin
        if (st.slot[k] && st.slot[pvs_pkg::SLOT_SEL + 8*k +: 6] == nb[9:4]) begin
          m = 1'b1;
          mc = 2'(k);
        end
      end
      if (nb[3:0] == 4'h0) begin
        next_st.active = m & st.lock;
        if (m && st.lock) begin
          next_st.ch = mc;
          if (st.full[mc]) begin
            next_st.txsh = fmt_tx(st.hold[mc], st.fmt, raw);
            next_st.full[mc] = 1'b0;
          end else begin
            next_st.txsh = fmt_tx(16'h0000, st.fmt, raw);
            uset[mc] = 1'b1;
          end
        end
      end
      idx = msb ? 4'hf - nb[3:0] : nb[3:0];
      if (next_st.active) begin
        next_st.dout_oe = 1'b1;
        next_st.dout = (nb[3:0] == 4'h0) ? next_st.txsh[idx] : st.txsh[idx];
      end else begin
        next_st.dout_oe = 1'b0;
      end
    end else if (fall) begin
      idx = msb ? 4'hf - st.bitcnt[3:0] : st.bitcnt[3:0];
      if (st.active) begin
        next_st.rxsh[idx] = st.din_sy[1];
        if (st.bitcnt[3:0] == 4'hf) begin
          next_st.dout_oe = 1'b0;
          next_st.active = 1'b0;
          rxw = next_st.rxsh >> st.fmt[pvs_pkg::FMT_POS +: 2];
          next_st.push = 1'b1;
          next_st.pdata[17:16] = st.ch;
          // in linear mode spare bits are dropped and the sample sign extends; other modes pass the word whole
          next_st.pdata[15:0] = raw ? next_st.rxsh : {{3{rxw[12]}}, rxw[12:0]};
        end
      end
      if (!master) begin
        next_st.fs_prev = st.sync_sy[1];
        if (!st.ctrl[pvs_pkg::CTRL_LONG] && st.sync_sy[1]) begin
          // next rising edge begins bit 0
          next_st.bitcnt = 10'(flen - 11'h001);
          next_st.lock = 1'b1;
        end else if (st.ctrl[pvs_pkg::CTRL_LONG] && st.sync_sy[1] && !st.fs_prev) begin
          next_st.bitcnt = 10'h000;
          next_st.lock = 1'b1;
        end
      end
    end

    // a word that finds the buffer full is lost
    if (st.push && !buf_ready) begin
      oset[st.pdata[17:16]] = 1'b1;
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      next_st.ack = 1'b1;
      case (wb_adr_i)
        pvs_pkg::ADR_CTRL: next_st.rdat = st.ctrl;
        pvs_pkg::ADR_FMT: next_st.rdat = st.fmt;
        pvs_pkg::ADR_SLOT: next_st.rdat = st.slot;
        pvs_pkg::ADR_STAT: next_st.rdat = {23'h0, st.lock, 1'b0, st.unr, 1'b0, st.ovr};
        pvs_pkg::ADR_DIV: next_st.rdat = {16'h0000, st.div};
        pvs_pkg::ADR_TX0: next_st.rdat = {st.full[0], 15'h0000, st.hold[0]};
        pvs_pkg::ADR_TX1: next_st.rdat = {st.full[1], 15'h0000, st.hold[1]};
        pvs_pkg::ADR_TX2: next_st.rdat = {st.full[2], 15'h0000, st.hold[2]};
        default: next_st.rdat = 32'h0000_0000;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i)
          pvs_pkg::ADR_CTRL: next_st.ctrl = wmask(st.ctrl, wb_dat_i, wb_sel_i);
          pvs_pkg::ADR_FMT: next_st.fmt = wmask(st.fmt, wb_dat_i, wb_sel_i);
          pvs_pkg::ADR_SLOT: next_st.slot = wmask(st.slot, wb_dat_i, wb_sel_i);
          pvs_pkg::ADR_STAT: begin
            if (wb_sel_i[0]) begin
              clr_o = wb_dat_i[2:0];
              clr_u = wb_dat_i[pvs_pkg::STAT_UNR +: 3];
            end
          end
          pvs_pkg::ADR_DIV: begin
            next_st.div = 16'(wmask({16'h0000, st.div}, wb_dat_i, wb_sel_i));
          end
          pvs_pkg::ADR_TX0, pvs_pkg::ADR_TX1, pvs_pkg::ADR_TX2: begin
            mc = 2'((wb_adr_i - pvs_pkg::ADR_TX0) >> 2);
            next_st.hold[mc] = 16'(wmask({16'h0000, st.hold[mc]}, wb_dat_i, wb_sel_i));
            next_st.full[mc] = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    // a status event in the clearing cycle survives the clear
    next_st.ovr = (st.ovr & ~clr_o) | oset;
    next_st.unr = (st.unr & ~clr_u) | uset;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctrl <= pvs_pkg::CTRL_RST;
      st.fmt <= pvs_pkg::FMT_RST;
      st.slot <= pvs_pkg::SLOT_RST;
      st.div <= pvs_pkg::DIV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // received word buffer
  // ****************************************
  pvs_buf2 #(
    .W(18)
  ) u_rxbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(st.push),
    .in_data_i(st.pdata),
    .in_ready_o(buf_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(buf_q),
    .out_ready_i(rx_ready_i)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign rx_data_o = buf_q[15:0];
  assign rx_chan_o = buf_q[17:16];
  assign wb_dat_o = st.rdat;
  assign wb_ack_o = st.ack;
  assign bclk_o = st.bclk;
  assign bclk_oe_o = st.pin_oe;
  assign sync_o = st.sync;
  assign sync_oe_o = st.pin_oe;
  assign dout_o = st.dout;
  assign dout_oe_o = st.dout_oe;

endmodule

// ==== pvs_port_checker.sv ====
/* assertions on the ports of the pcm voice slot port.
   assumes the bind below attaches it to every pvs_port. */
`timescale 1ns/1ps
module pvs_port_checker (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input logic bclk_o,
  input logic bclk_oe_o,
  input logic sync_o,
  input logic sync_oe_o,
  input logic dout_oe_o,
  input logic rx_valid_o,
  input logic [15:0] rx_data_o,
  input logic [1:0] rx_chan_o,
  input logic rx_ready_i
);
  // ********
  // bus and link properties
  // ********
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_bclk_owned: assert property (bclk_o |-> bclk_oe_o)
    else $error("bit clock high while not driven");
  a_sync_owned: assert property (sync_o |-> sync_oe_o)
    else $error("sync high while not driven");
  a_roles_paired: assert property (sync_oe_o == bclk_oe_o)
    else $error("clock and sync roles differ");
  a_release_clk_low: assert property ($fell(dout_oe_o) && bclk_oe_o |-> !bclk_o)
    else $error("data released while bit clock high");
  a_rx_word_held: assert property (rx_valid_o && !rx_ready_i |=>
      rx_valid_o && $stable(rx_data_o) && $stable(rx_chan_o))
    else $error("rx word lost before taken");
  a_rx_chan_range: assert property (rx_valid_o |-> rx_chan_o < 2'd3)
    else $error("rx channel out of range");
endmodule
bind pvs_port pvs_port_checker u_pvs_port_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bclk_o(bclk_o),
  .bclk_oe_o(bclk_oe_o), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .dout_oe_o(dout_oe_o),
  .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_chan_o(rx_chan_o), .rx_ready_i(rx_ready_i));

// ==== pvs_port_tb.sv ====
/* testbench of the pcm voice slot port: master and slave frames against
   the codec model, rx buffer fill and drain.
   assumes the design files, the codec model and the checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module pvs_port_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, bclk_o, bclk_oe_o, sync_o, sync_oe_o, dout_o, dout_oe_o, rx_valid_o;
  logic [15:0] rx_data_o, got;
  logic [1:0] rx_chan_o;
  logic rx_ready_i = 1'b1;
  logic run = 1'b0;
  logic [3:0] slot = 4'h0;
  logic c_bclk, c_sync, din;
  wire logic bclk = bclk_oe_o ? bclk_o : c_bclk;
  wire logic fs = sync_oe_o ? sync_o : c_sync;
  logic [31:0] rates[4] = '{32'h3, 32'h43, 32'h4b, 32'h13};
  int plen[4] = '{128, 512, 256, 256};
  int words, leak, w, p;
  int errors = 0;
  int n_checks = 0;
  always #4 clk_i = ~clk_i;
  pvs_port u_pvs_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bclk_i(bclk), .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .sync_i(fs),
    .sync_o(sync_o), .sync_oe_o(sync_oe_o), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_chan_o(rx_chan_o), .rx_ready_i(rx_ready_i));
  pvs_codec #(.FRAME(32)) u_pvs_codec (.run_i(run), .bclk_i(bclk), .sync_i(fs), .dout_i(dout_o),
    .dout_oe_i(dout_oe_o), .slot_i(slot), .word_i(16'hb3c8), .bclk_o(c_bclk), .sync_o(c_sync),
    .din_o(din), .got_o(got), .words_o(words), .leak_o(leak));
  // ********
  // tasks
  // ********
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic to();
    errors++;
    finish_test();
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) to();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 20000 && words < n; k++) @(posedge clk_i);
    if (words < n) to();
  endtask
  task automatic expect_word(input logic [15:0] e);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wait_words(words + 1);
      hit |= (got === e);
    end
    `CHK(hit, 1'b1)
  endtask
  // w: cycles sync is high, p: cycles from one rise to the next
  task automatic sync_meas(output int w, output int p);
    int ph;
    ph = 0;
    w = 0;
    p = 0;
    for (int k = 0; k < 4000 && ph < 4; k++) begin
      @(posedge clk_i);
      if (sync_o === ph[0]) ph++;
      w += (ph == 2);
      p += (ph == 2 || ph == 3);
    end
    if (ph < 4) to();
  endtask
  // looks one edge on, so a word just taken is never seen again
  task automatic pop(input logic [15:0] d, input logic [1:0] c);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (rx_valid_o !== 1'b1 && k < 4000);
    if (rx_valid_o !== 1'b1) begin
      to();
    end else begin
      `CHK(rx_data_o, d)
      `CHK(rx_chan_o, c)
      rx_ready_i <= 1'b1;
      @(posedge clk_i);
      rx_ready_i <= 1'b0;
    end
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pvs_pkg::ADR_CTRL, pvs_pkg::CTRL_RST);
    rd(pvs_pkg::ADR_FMT, pvs_pkg::FMT_RST);
    rd(pvs_pkg::ADR_SLOT, pvs_pkg::SLOT_RST);
    rd(pvs_pkg::ADR_DIV, {16'h0000, pvs_pkg::DIV_RST});
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    // master, short sync, channel 0 on slot 0, bit period 8 clocks
    wb(1'b1, pvs_pkg::ADR_DIV, 32'h3);
    wb(1'b1, pvs_pkg::ADR_SLOT, 32'h1);
    wb(1'b1, pvs_pkg::ADR_CTRL, 32'h3);
    wait_words(words + 1);
    `CHK(bclk_oe_o, 1'b1)
    wb(1'b1, pvs_pkg::ADR_TX0, 32'h1a5b);
    expect_word(16'hd2d8);
    rx_ready_i <= 1'b0;
    wait_words(words + 4);
    wb(1'b0, pvs_pkg::ADR_STAT, 32'h0);
    `CHK(q & 32'h11, 32'h11)
    pop(16'hf679, 2'd0);
    pop(16'hf679, 2'd0);
    foreach (rates[i]) begin
      wb(1'b1, pvs_pkg::ADR_CTRL, rates[i]);
      sync_meas(w, p);
      sync_meas(w, p);
      `CHK(p, plen[i])
      `CHK(w, 8)
    end
    wb(1'b1, pvs_pkg::ADR_CTRL, 32'h7);
    sync_meas(w, p);
    sync_meas(w, p);
    `CHK(w, 24)
    `CHK(p, 128)
    wb(1'b1, pvs_pkg::ADR_CTRL, 32'h0);
    wb(1'b1, pvs_pkg::ADR_STAT, 32'h77);
    wb(1'b0, pvs_pkg::ADR_STAT, 32'h0);
    `CHK(q & 32'h77, 32'h0)
    // slave to the codec, two slots, channel 1 on slot 1, lsb first, ones fill
    run <= 1'b1;
    slot <= 4'h1;
    rx_ready_i <= 1'b1;
    wb(1'b1, pvs_pkg::ADR_FMT, 32'h0b);
    wb(1'b1, pvs_pkg::ADR_SLOT, 32'h0001_0002);
    wb(1'b1, pvs_pkg::ADR_CTRL, 32'h21);
    wait_words(words + 3);
    `CHK(bclk_oe_o, 1'b0)
    wb(1'b0, pvs_pkg::ADR_STAT, 32'h0);
    `CHK(q[pvs_pkg::STAT_LOCK], 1'b1)
    wb(1'b1, pvs_pkg::ADR_TX1, 32'h0a5c);
    expect_word(16'he74a);
    rx_ready_i <= 1'b0;
    pop(16'h0279, 2'd1);
    // transparent mode, msb first: words pass unchanged both ways
    rx_ready_i <= 1'b1;
    wb(1'b1, pvs_pkg::ADR_FMT, 32'h07);
    wb(1'b1, pvs_pkg::ADR_CTRL, 32'h121);
    wb(1'b1, pvs_pkg::ADR_TX1, 32'h1234);
    expect_word(16'h1234);
    rx_ready_i <= 1'b0;
    pop(16'hb3c8, 2'd1);
    `CHK(leak, 0)
    finish_test();
  end
endmodule
